//--- gpio_pkg.sv
// gpio_pkg: widths, reset values and pin-group layout for the general purpose port block
// assumes: imported by the port bank and its top; no bus, all settings are plain ports
package gpio_pkg;
  localparam int W0  = 7;  // group zero
  localparam int W1  = 8;  // analog shared input port
  localparam int W2  = 8;
  localparam int W3  = 8;
  localparam int W4  = 8;  // muxed address/data port
  localparam int W5  = 8;  // middle address port
  localparam int W6  = 8;  // upper address/strobe port
  localparam int W7  = 3;
  localparam int W8  = 8;  // key return port
  localparam int W9  = 6;  // open-drain middle-voltage port
  localparam int W10 = 4;
  localparam int W12 = 8;
  localparam int W13 = 2;
  localparam int WALL = 72;  // sum of all bidirectional push-pull bits (groups 0,2..8,10,12,13)
  localparam logic [7:0] RST_DIR_IN  = 8'hff;  // 1 = input after reset
  localparam logic [7:0] RST_LATCH   = 8'h00;
  localparam logic [7:0] RST_PULLUP  = 8'h00;
  localparam logic       RST_FLAG    = 1'b0;
  // pull-up style of a group
  typedef enum logic [1:0] {
    PU_ALWAYS  = 2'b01,
    PU_IN_ONLY = 2'b11,
    PU_NONE    = 2'b10
  } pullup_mode_e;
endpackage

//--- port_bank.sv
// port_bank: one bidirectional port group of up to eight bits
// assumes: pin input already synchronised by the top; alternate function signals are on clk
module port_bank
  import gpio_pkg::*;
#(
  parameter int           WIDTH = 8,
  parameter pullup_mode_e PMODE = PU_ALWAYS
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             wr_latch,
  input  wire logic [WIDTH-1:0] latch_data,
  input  wire logic             wr_dir,
  input  wire logic [WIDTH-1:0] dir_in_data,
  input  wire logic             wr_pullup,
  input  wire logic [WIDTH-1:0] pullup_data,
  input  wire logic [WIDTH-1:0] alt_en,
  input  wire logic [WIDTH-1:0] alt_out,
  input  wire logic [WIDTH-1:0] alt_oe,
  input  wire logic [WIDTH-1:0] pin_sync,
  output logic      [WIDTH-1:0] pin_out,
  output logic      [WIDTH-1:0] pin_oe,
  output logic      [WIDTH-1:0] pull_en,
  output logic      [WIDTH-1:0] read_data,
  output logic      [WIDTH-1:0] latch_q,
  output logic      [WIDTH-1:0] dir_q
);
  logic [WIDTH-1:0] latch_reg;
  logic [WIDTH-1:0] dir_in_reg;
  logic [WIDTH-1:0] pullup_reg;
  logic [WIDTH-1:0] out_reg;
  logic [WIDTH-1:0] oe_reg;
  logic [WIDTH-1:0] pe_reg;
  logic [WIDTH-1:0] rd_reg;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) latch_reg <= RST_LATCH[WIDTH-1:0];
    else if (wr_latch) latch_reg <= latch_data;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) dir_in_reg <= RST_DIR_IN[WIDTH-1:0];
    else if (wr_dir) dir_in_reg <= dir_in_data;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) pullup_reg <= RST_PULLUP[WIDTH-1:0];
    else if (wr_pullup && PMODE != PU_NONE) pullup_reg <= pullup_data;
  end

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          out_reg[i] <= 1'b0;
          oe_reg[i]  <= 1'b0;
          pe_reg[i]  <= 1'b0;
          rd_reg[i]  <= 1'b0;
        end else begin
          // alternate function takes the driver, reads still show the pin
          out_reg[i] <= alt_en[i] ? alt_out[i] : latch_reg[i];
          oe_reg[i]  <= alt_en[i] ? alt_oe[i] : ~dir_in_reg[i];
          rd_reg[i]  <= pin_sync[i];
          case (PMODE)
            PU_ALWAYS:  pe_reg[i] <= pullup_reg[i];
            PU_IN_ONLY: pe_reg[i] <= pullup_reg[i] & ~(alt_en[i] ? alt_oe[i] : ~dir_in_reg[i]);
            default:    pe_reg[i] <= 1'b0;
          endcase
        end
      end
    end
  endgenerate

  assign pin_out   = out_reg;
  assign pin_oe    = oe_reg;
  assign pull_en   = pe_reg;
  assign read_data = rd_reg;
  assign latch_q   = latch_reg;
  assign dir_q     = dir_in_reg;
endmodule

//--- gpio_ports.sv
// gpio_ports: all general purpose port groups, key-return flag, input-only and open-drain ports
// assumes: software settings arrive as plain write strobes on clk; pins are asynchronous
// Operation
// - every bidirectional pin has its own direction bit set by software.
// - groups 0, 2, 3, 7, 8, 10 and 12 have per-pin pull-ups active in either direction.
// - groups 4, 5 and 6 have pull-ups that act only while the pin is an input.
// - a falling edge on any key return pin sets the key return flag to one.
// - the analog shared port is input only, with no driver and no direction bit.
// - the middle-voltage port is open-drain, pulls only low, has direction bits and no pull-up.
module gpio_ports
  import gpio_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   resetn,
  input  wire logic [13:0]            wr_latch,
  input  wire logic [13:0]            wr_dir,
  input  wire logic [13:0]            wr_pullup,
  input  wire logic [7:0]             wdata,
  input  wire logic [gpio_pkg::WALL-1:0] alt_en,
  input  wire logic [gpio_pkg::WALL-1:0] alt_out,
  input  wire logic [gpio_pkg::WALL-1:0] alt_oe,
  input  wire logic [gpio_pkg::WALL-1:0] pin_in,
  output logic      [gpio_pkg::WALL-1:0] pin_out,
  output logic      [gpio_pkg::WALL-1:0] pin_oe,
  output logic      [gpio_pkg::WALL-1:0] pull_en,
  output logic      [gpio_pkg::WALL-1:0] read_data,
  input  wire logic [gpio_pkg::W1-1:0] analog_shared_input_port_in,
  output logic      [gpio_pkg::W1-1:0] analog_shared_input_port_rd,
  input  wire logic [gpio_pkg::W9-1:0] open_drain_midvolt_port_in,
  output logic      [gpio_pkg::W9-1:0] open_drain_midvolt_port_out,
  output logic      [gpio_pkg::W9-1:0] open_drain_midvolt_port_oe,
  output logic      [gpio_pkg::W9-1:0] open_drain_midvolt_port_rd,
  input  wire logic                   key_return_irq_clear,
  output logic                        key_return_irq_flag
);
  import gpio_pkg::*;

  // group order in the flat vectors: index 0..10 = groups 0,2,3,4,5,6,7,8,10,12,13 (11 groups)
  localparam int NG = 11;
  localparam int GW [NG] = '{W0, W2, W3, W4, W5, W6, W7, W8, W10, W12, W13};
  localparam int GN [NG] = '{0, 2, 3, 4, 5, 6, 7, 8, 10, 12, 13};
  localparam pullup_mode_e GM [NG] = '{PU_ALWAYS, PU_ALWAYS, PU_ALWAYS, PU_IN_ONLY, PU_IN_ONLY,
                                       PU_IN_ONLY, PU_ALWAYS, PU_ALWAYS, PU_ALWAYS, PU_ALWAYS, PU_NONE};
  localparam int KEY_BASE = W0 + W2 + W3 + W4 + W5 + W6 + W7;

  function automatic int base_of(input int g);
    int s;
    s = 0;
    for (int k = 0; k < g; k++) s += GW[k];
    return s;
  endfunction

  logic [WALL-1:0] pin_s1;
  logic [WALL-1:0] pin_s2;
  logic [W1-1:0]   an_s1;
  logic [W1-1:0]   an_s2;
  logic [W9-1:0]   od_s1;
  logic [W9-1:0]   od_s2;

  // two-stage synchronisers; only the second stage feeds logic
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      an_s1  <= '0;
      an_s2  <= '0;
      od_s1  <= '0;
      od_s2  <= '0;
    end else begin
      pin_s1 <= pin_in;
      pin_s2 <= pin_s1;
      an_s1  <= analog_shared_input_port_in;
      an_s2  <= an_s1;
      od_s1  <= open_drain_midvolt_port_in;
      od_s2  <= od_s1;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NG; g++) begin : g_grp
      localparam int B = base_of(g);
      localparam int N = GW[g];
      localparam int P = GN[g];
      port_bank #(
        .WIDTH (N),
        .PMODE (GM[g])
      ) u_bank (
        .clk         (clk),
        .resetn      (resetn),
        .wr_latch    (wr_latch[P]),
        .latch_data  (wdata[N-1:0]),
        .wr_dir      (wr_dir[P]),
        .dir_in_data (wdata[N-1:0]),
        .wr_pullup   (wr_pullup[P]),
        .pullup_data (wdata[N-1:0]),
        .alt_en      (alt_en[B+N-1:B]),
        .alt_out     (alt_out[B+N-1:B]),
        .alt_oe      (alt_oe[B+N-1:B]),
        .pin_sync    (pin_s2[B+N-1:B]),
        .pin_out     (pin_out[B+N-1:B]),
        .pin_oe      (pin_oe[B+N-1:B]),
        .pull_en     (pull_en[B+N-1:B]),
        .read_data   (read_data[B+N-1:B]),
        .latch_q     (),
        .dir_q       ()
      );
    end
  endgenerate

  // input-only port: no latch, no direction, only a registered pin read
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) analog_shared_input_port_rd <= '0;
    else analog_shared_input_port_rd <= an_s2;
  end

  // open-drain port: a latched zero on an output pin pulls low, a one releases
  logic [W9-1:0] od_latch_reg;
  logic [W9-1:0] od_dir_in_reg;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) od_latch_reg <= RST_LATCH[W9-1:0];
    else if (wr_latch[9]) od_latch_reg <= wdata[W9-1:0];
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) od_dir_in_reg <= RST_DIR_IN[W9-1:0];
    else if (wr_dir[9]) od_dir_in_reg <= wdata[W9-1:0];
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      open_drain_midvolt_port_oe <= '0;
      open_drain_midvolt_port_rd <= '0;
    end else begin
      open_drain_midvolt_port_oe <= ~od_dir_in_reg & ~od_latch_reg;
      open_drain_midvolt_port_rd <= od_s2;
    end
  end
  assign open_drain_midvolt_port_out = '0;  // only ever drives low

  // key return: falling edge on any bit sets the flag; a set in the clear cycle wins
  logic [W8-1:0] key_prev_reg;
  logic          key_fall;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) key_prev_reg <= '0;  // matches the low reset of the synchroniser, so release is no fall
    else key_prev_reg <= pin_s2[KEY_BASE+W8-1:KEY_BASE];
  end
  assign key_fall = |(key_prev_reg & ~pin_s2[KEY_BASE+W8-1:KEY_BASE]);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) key_return_irq_flag <= RST_FLAG;
    else if (key_fall) key_return_irq_flag <= 1'b1;
    else if (key_return_irq_clear) key_return_irq_flag <= 1'b0;
  end
endmodule

//--- gpio_monitor.sv
// gpio_monitor: port-level assertions for gpio_ports
// assumes: bound to gpio_ports, one clk domain, resetn async active low
module gpio_monitor
  import gpio_pkg::*;
(
  input wire logic                      clk,
  input wire logic                      resetn,
  input wire logic [13:0]               wr_latch,
  input wire logic [13:0]               wr_dir,
  input wire logic [13:0]               wr_pullup,
  input wire logic [7:0]                wdata,
  input wire logic [gpio_pkg::WALL-1:0] alt_en,
  input wire logic [gpio_pkg::WALL-1:0] alt_oe,
  input wire logic [gpio_pkg::WALL-1:0] pin_in,
  input wire logic [gpio_pkg::WALL-1:0] pin_oe,
  input wire logic [gpio_pkg::WALL-1:0] pull_en,
  input wire logic [gpio_pkg::W1-1:0]   analog_shared_input_port_in,
  input wire logic [gpio_pkg::W1-1:0]   analog_shared_input_port_rd,
  input wire logic [gpio_pkg::W9-1:0]   open_drain_midvolt_port_out,
  input wire logic [gpio_pkg::W9-1:0]   open_drain_midvolt_port_oe,
  input wire logic                      key_return_irq_clear,
  input wire logic                      key_return_irq_flag
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // output direction written to group 0 bit 0, no alternate takeover next cycle
  sequence s_dir_out_write;
    wr_dir[0] && !wdata[0] ##1 !wr_dir[0] && !alt_en[0];
  endsequence
  sequence s_pull_write;
    wr_pullup[0] && wdata[0] ##1 !wr_pullup[0];
  endsequence
  sequence s_analog_still;
    $stable(analog_shared_input_port_in) [*5];
  endsequence
  // fall must survive the two sync stages before the flag may be judged
  sequence s_key_fall;
    $fell(pin_in[50]) ##1 (!pin_in[50] && !key_return_irq_clear) [*4];
  endsequence
  AST_DIR_OUT: assert property (s_dir_out_write |=> pin_oe[0])
    else $error("output direction write did not enable the driver");
  AST_PULL_ANY: assert property (s_pull_write |-> ##[1:2] pull_en[0])
    else $error("pull-up enable write did not reach the pin");
  AST_PULL_IN: assert property (pin_oe[23] |-> !pull_en[23])
    else $error("input-only pull-up active while driving");
  AST_KEY_SET: assert property (s_key_fall |-> key_return_irq_flag)
    else $error("key return fall did not set the flag");
  AST_ANALOG: assert property (s_analog_still
    |-> analog_shared_input_port_rd == analog_shared_input_port_in)
    else $error("input-only port read differs from pins");
  AST_OD_LOW: assert property (open_drain_midvolt_port_out == '0)
    else $error("open-drain port drives high");
  AST_OD_RELEASE: assert property (wr_latch[9] && wdata[0] |=> ##1 !open_drain_midvolt_port_oe[0])
    else $error("open-drain port pulls low with a latched one");
  AST_ALT: assert property (alt_en[7] && alt_oe[7] |=> pin_oe[7])
    else $error("alternate function drive not on pin");
endmodule

bind gpio_ports gpio_monitor gpio_monitor_i (.*);

//--- board_model.sv
// board_model: board circuitry at the port pins
// assumes: testbench chooses which pins the board drives; bare pins wander
module board_model
  import gpio_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic [gpio_pkg::WALL-1:0] pin_out,
  input  wire logic [gpio_pkg::WALL-1:0] pin_oe,
  input  wire logic [gpio_pkg::WALL-1:0] pull_en,
  input  wire logic [gpio_pkg::WALL-1:0] ext_en,
  input  wire logic [gpio_pkg::WALL-1:0] ext_val,
  input  wire logic [gpio_pkg::W9-1:0]   od_oe,
  input  wire logic [gpio_pkg::W9-1:0]   od_ext,
  output logic      [gpio_pkg::WALL-1:0] pin_lvl,
  output logic      [gpio_pkg::W9-1:0]   od_lvl
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [gpio_pkg::WALL-1:0] float_reg = '0;
  // a pin nobody holds toggles, so a stale value is never read back
  always @(posedge clk) float_reg <= ~float_reg;
  always_comb pin_lvl = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
                      | (~pin_oe & ~ext_en & (pull_en | float_reg));
  always_comb od_lvl = ~od_oe & od_ext;
endmodule

//--- testbench.sv
// testbench: random and corner tests of gpio_ports with a board model
// assumes: gpio_pkg, gpio_ports, board_model and gpio_monitor compiled first
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import gpio_pkg::*;
  logic            clk = 0, resetn = 0, clr = 0, o, x, flag;
  logic [13:0]     wr_l = 0, wr_d = 0, wr_p = 0;
  logic [7:0]      wdata = 0, an_in = 0, v, d, p, k, m;
  logic [WALL-1:0] alt_en = 0, alt_out = 0, alt_oe = 0, ext_en = 0, ext_val = 0;
  logic [WALL-1:0] p_in, p_out, p_oe, p_pu, rd;
  logic [W1-1:0]   an_rd;
  logic [W9-1:0]   od_out, od_oe, od_rd, od_lvl, od_ext = '1;
  int              err_total = 0, checks_done = 0, cyc = 0, g, b;
  int              off [14] = '{0, 0, 7, 15, 23, 31, 39, 47, 50, 0, 58, 0, 62, 70};
  int              wid [14] = '{7, 0, 8, 8, 8, 8, 8, 3, 8, 0, 4, 0, 8, 2};
  int              grp [11] = '{0, 2, 3, 4, 5, 6, 7, 8, 10, 12, 13};
  gpio_ports gpio_ports_i (.clk, .resetn, .wr_latch(wr_l), .wr_dir(wr_d), .wr_pullup(wr_p), .wdata,
    .alt_en, .alt_out, .alt_oe, .pin_in(p_in), .pin_out(p_out), .pin_oe(p_oe), .pull_en(p_pu),
    .read_data(rd), .analog_shared_input_port_in(an_in), .analog_shared_input_port_rd(an_rd),
    .open_drain_midvolt_port_in(od_lvl), .open_drain_midvolt_port_out(od_out),
    .open_drain_midvolt_port_oe(od_oe), .open_drain_midvolt_port_rd(od_rd),
    .key_return_irq_clear(clr), .key_return_irq_flag(flag));
  board_model board_model_i (.clk, .pin_out(p_out), .pin_oe(p_oe), .pull_en(p_pu), .ext_en,
    .ext_val, .od_oe, .od_ext, .pin_lvl(p_in), .od_lvl);
  always #25 clk = ~clk;
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ceiling sits well above the roughly 420 cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      wrap_up();
    end
  end
  task automatic chk(string n, logic [WALL-1:0] s, logic [WALL-1:0] e);
    checks_done++;
    if (s !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(ref logic [13:0] s, input int gi, input logic [7:0] dv);
    s[gi] = 1'b1;
    wdata = dv;
    tick(1);
    s = '0;
  endtask
  function automatic logic [7:0] fld(logic [WALL-1:0] xv, int gi);
    return 8'((xv >> off[gi]) & ((1 << wid[gi]) - 1));
  endfunction
  // groups 4..6 pull only on inputs, group 13 has none
  function automatic logic [7:0] pu_exp(int gi, logic [7:0] dir, logic [7:0] mk);
    if (gi == 13)
      return 8'h00;
    return (gi >= 4 && gi <= 6) ? dir & mk : mk;
  endfunction
  initial begin
    void'($urandom(12105));
    tick(10);
    resetn = 1;
    tick(1);
    chk("reset oe", p_oe, '0);
    chk("reset pull", p_pu, '0);
    chk("reset flag", flag, 0);
    foreach (grp[i]) for (int r = 0; r < 3; r++) begin
      g = grp[i];
      m = 8'((1 << wid[g]) - 1);
      v = (r == 0) ? 8'h00 : (r == 1) ? 8'hff : 8'($urandom);
      d = 8'($urandom);
      wr(wr_l, g, d);
      wr(wr_d, g, v);
      wr(wr_p, g, 8'hff);
      tick(6);
      p = pu_exp(g, v, m);
      k = (~v | p) & m;
      chk("pin_oe", fld(p_oe, g), ~v & m);
      chk("pin_out", fld(p_out, g), d & m);
      chk("pull_en", fld(p_pu, g), p);
      chk("read", fld(rd, g) & k, ((d & ~v) | (p & v)) & k);
    end
    $display("test groups done");
    for (int n = 0; n < 8; n++) begin
      // first pass is a fixed corner: alternate driver on group 2 bit 0
      b = (n == 0) ? 7 : int'($urandom_range(71));
      o = (n == 0) ? 1'b1 : 1'($urandom);
      x = 1'($urandom);
      alt_en[b] = 1'b1;
      alt_oe[b] = o;
      alt_out[b] = x;
      ext_en[b] = !o;
      ext_val[b] = x;
      tick(6);
      chk("alt oe", p_oe[b], o);
      chk("alt read", rd[b], x);
      alt_en = '0;
      ext_en = '0;
      tick(1);
    end
    $display("test alternate done");
    wr(wr_d, 8, 8'hff);
    ext_en[57:50] = '1;
    ext_val[57:50] = '1;
    tick(5);
    clr = 1;
    tick(1);
    clr = 0;
    tick(1);
    chk("flag idle", flag, 0);
    ext_val[50 + $urandom_range(7)] = 1'b0;
    tick(6);
    chk("flag set", flag, 1);
    clr = 1;
    tick(1);
    clr = 0;
    tick(1);
    chk("flag clear", flag, 0);
    $display("test key return done");
    repeat (4) begin
      an_in = 8'($urandom);
      tick(4);
      chk("analog read", an_rd, an_in);
      v = 8'($urandom);
      d = 8'($urandom);
      wr(wr_l, 9, d);
      wr(wr_d, 9, v);
      tick(5);
      chk("od oe", od_oe, ~v & ~d & 8'h3f);
      chk("od out", od_out, 0);
      chk("od read", od_rd, (v | d) & 8'h3f);
    end
    $display("test input-only and open-drain done");
    wrap_up();
  end
endmodule
